// >>> pkg/prd_map.svh
// address map, internal register indices, reset values and part code for the register decoder
// assumes register indices equal the 16-bit local byte address; bus byte address is four times it
`ifndef PRD_MAP_SVH
`define PRD_MAP_SVH
`define PRD_PIM0_LO    16'h0000
`define PRD_PIM0_HI    16'h0009
`define PRD_MMC0_LO    16'h000A
`define PRD_MMC0_HI    16'h000B
`define PRD_PIM1_LO    16'h000C
`define PRD_PIM1_HI    16'h000D
`define PRD_MMC1_LO    16'h0010
`define PRD_MMC1_HI    16'h0017
`define PRD_IDH_IDX    16'h001A
`define PRD_IDL_IDX    16'h001B
`define PRD_PIM2_LO    16'h001C
`define PRD_PIM2_HI    16'h001F
`define PRD_DBG_LO     16'h0020
`define PRD_DBG_HI     16'h002F
`define PRD_CPM0_LO    16'h0034
`define PRD_CPM0_HI    16'h003F
`define PRD_TIM_LO     16'h0040
`define PRD_TIM_HI     16'h006F
`define PRD_ADC_LO     16'h0070
`define PRD_ADC_HI     16'h009F
`define PRD_PWM_LO     16'h00A0
`define PRD_PWM_HI     16'h00C7
`define PRD_SCI0_LO    16'h00C8
`define PRD_SCI0_HI    16'h00CF
`define PRD_SCI1_LO    16'h00D0
`define PRD_SCI1_HI    16'h00D7
`define PRD_SPI_LO     16'h00D8
`define PRD_SPI_HI     16'h00DF
`define PRD_FCTL_LO    16'h0100
`define PRD_FCTL_HI    16'h0113
`define PRD_INT_IDX    16'h0120
`define PRD_HSD_LO     16'h0140
`define PRD_HSD_HI     16'h0147
`define PRD_LSD_LO     16'h0150
`define PRD_LSD_HI     16'h0157
`define PRD_LIN_LO     16'h0160
`define PRD_LIN_HI     16'h0167
`define PRD_SUPPLY_SENSE_BLOCK_LO    16'h0170
`define PRD_SUPPLY_SENSE_BLOCK_HI    16'h0177
`define PRD_PIM3_LO    16'h0240
`define PRD_PIM3_HI    16'h027F
`define PRD_CPM1_LO    16'h02F0
`define PRD_CPM1_HI    16'h02FF
`define PRD_PFL_LO     16'h8000
`define PRD_PFL_HI     16'hBFFF
`define PRD_MODE_IDX   16'h0011
`define PRD_PROGRAM_PAGE_REGISTER_IDX  16'h0015
`define PRD_PULL_IDX   16'h0250
`define PRD_PULL_LAST  16'h0258
`define PRD_PROGRAM_PAGE_REGISTER_RST  4'h0
`define PRD_PULL_RST   45'h000_001F_FE01
`define PRD_PART_ID    16'h5AC3
`endif

// >>> pkg/prd_pkg.sv
// types shared by the register decoder: states, module selects, pull control, full state record
// assumes the map header supplies all numbers
package prd_pkg;
    typedef enum logic [5:0] {
        PRD_ST_IDLE  = 6'h01,
        PRD_ST_WACC  = 6'h02,
        PRD_ST_BRESP = 6'h04,
        PRD_ST_RACC  = 6'h08,
        PRD_ST_RWAIT = 6'h10,
        PRD_ST_RRESP = 6'h20
    } prd_state_type;

    // one bit per peripheral; at most one is high
    typedef struct packed {
        logic port_integration_block, mmc, dbg, clock_power_block, tim, adc, pwm, sci0, sci1, spi;
        logic flash_ctl, intr, hsd, lsd, lin, supply_sense_block, pflash;
    } prd_sel_type;

    // per-port pull enable and direction (up=1), port E shares one pull-down enable
    typedef struct packed {
        logic [5:0] ad_en, ad_up, p_en, p_up, s_en, s_up;
        logic [3:0] t_en, t_up;
        logic       e_dn;
    } prd_pull_type;

    typedef struct packed {
        prd_state_type state;
        logic awready, wready, bvalid, arready, rvalid;
        logic aw_have, w_have, addr_ok, wen;
        logic [15:0] addr;
        logic [7:0]  wbyte, rdata;
        prd_sel_type sel;
        logic [15:0] per_addr;
        logic [7:0]  per_wdata;
        logic        per_we, per_re;
        logic [17:0] flash_addr;
        logic [3:0]  program_page_register;
        logic        mode;
        logic [2:0]  rst_sync, dbg_sync;
        logic        rst_filt, dbg_filt, drv_rst, chip_rst_n;
        prd_pull_type pull;
    } prd_regs_type;
endpackage

// >>> hdl/prd_decode.sv
// register address decoder: axi4-lite slave fanning byte accesses out to the peripheral selects
// assumes peripherals return read data combinationally while their select is high; one clock
//
// Contract
// - reserved writes change nothing and raise no module select
// - reserved reads answer all-zero data
// - two read-only id bytes, high at 0x001A, low at 0x001B, writes ignored
// - id value is a fixed per-revision constant
// - 0x8000-0xBFFF reaches 256K global space through the program page register
// - port block selected for 0x0000-0009, 000C-000D, 001C-001F, 0240-027F
// - memory map block selected for 0x000A-000B and 0x0010-0017
// - clock power block selected for 0x0034-003F and 0x02F0-02FF
// - timer selected for 0x0040-006F
// - converter selected for 0x0070-009F
// - pwm selected for 0x00A0-00C7
// - first serial port 0x00C8-00CF, second 0x00D0-00D7
// - spi selected for 0x00D8-00DF
// - flash controller registers selected for 0x0100-0113
// - interrupt block only at 0x0120, 0x0121-013F reserved
// - high-side 0x0140-0147, low-side 0x0150-0157, gap reserved
// - lin block 0x0160-0167, supply sense 0x0170-0177, up to 0x023F reserved
// - reset pin low from outside initialises; driven low on internal reset
// - mode pin level latched into mode bit at reset pin rising edge
// - analog, p and t port pulls disabled after reset, per-pin control
// - port e pull-downs share one bit, enabled after reset
// - port s pull-ups enabled after reset, per-pin selectable later
`timescale 1ns/1ps
`include "prd_map.svh"

module prd_decode #(
    parameter logic [15:0] PART_ID = `PRD_PART_ID // arbitrary neutral value
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RSTN,
    input  wire logic [31:0]          S_AXI_AWADDR,
    input  wire logic                 S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire logic [31:0]          S_AXI_WDATA,
    input  wire logic [3:0]           S_AXI_WSTRB,
    input  wire logic                 S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    output logic [1:0]                S_AXI_BRESP,
    output logic                      S_AXI_BVALID,
    input  wire logic                 S_AXI_BREADY,
    input  wire logic [31:0]          S_AXI_ARADDR,
    input  wire logic                 S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    output logic [31:0]               S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    output logic                      S_AXI_RVALID,
    input  wire logic                 S_AXI_RREADY,
    output prd_pkg::prd_sel_type      PERIPH_SEL,
    output logic [15:0]               PERIPH_ADDR,
    output logic [7:0]                PERIPH_WDATA,
    output logic                      PERIPH_WE,
    output logic                      PERIPH_RE,
    input  wire logic [7:0]           PERIPH_RDATA,
    output logic [17:0]               FLASH_ADDR,
    input  wire logic                 RESET_PIN_I,
    output logic                      RESET_PIN_O,
    output logic                      RESET_PIN_OE,
    input  wire logic                 INT_RESET_REQ,
    input  wire logic                 DEBUG_MODE_PIN_I,
    output logic                      MODE_SELECT,
    output logic                      CHIP_RESET_N,
    output prd_pkg::prd_pull_type     PULL
);

    prd_pkg::prd_regs_type q;
    prd_pkg::prd_regs_type d;

    // inclusive range test, shared by every decode line except the single-address interrupt select
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // address to module select; the ranges do not overlap so one bit at most is set
    function automatic prd_pkg::prd_sel_type decode(input logic [15:0] a, input logic ok);
        prd_pkg::prd_sel_type s;
        s = '0;
        if (ok)
        begin
            s.port_integration_block = in_rng(a, `PRD_PIM0_LO, `PRD_PIM0_HI)
                  | in_rng(a, `PRD_PIM1_LO, `PRD_PIM1_HI)
                  | in_rng(a, `PRD_PIM2_LO, `PRD_PIM2_HI)
                  | in_rng(a, `PRD_PIM3_LO, `PRD_PIM3_HI);
            s.mmc = in_rng(a, `PRD_MMC0_LO, `PRD_MMC0_HI)
                  | in_rng(a, `PRD_MMC1_LO, `PRD_MMC1_HI);
            s.dbg = in_rng(a, `PRD_DBG_LO, `PRD_DBG_HI);
            s.clock_power_block = in_rng(a, `PRD_CPM0_LO, `PRD_CPM0_HI)
                   | in_rng(a, `PRD_CPM1_LO, `PRD_CPM1_HI);
            s.tim = in_rng(a, `PRD_TIM_LO, `PRD_TIM_HI);
            s.adc = in_rng(a, `PRD_ADC_LO, `PRD_ADC_HI);
            s.pwm = in_rng(a, `PRD_PWM_LO, `PRD_PWM_HI);
            s.sci0 = in_rng(a, `PRD_SCI0_LO, `PRD_SCI0_HI);
            s.sci1 = in_rng(a, `PRD_SCI1_LO, `PRD_SCI1_HI);
            s.spi = in_rng(a, `PRD_SPI_LO, `PRD_SPI_HI);
            s.flash_ctl = in_rng(a, `PRD_FCTL_LO, `PRD_FCTL_HI);
            s.intr = (a == `PRD_INT_IDX);
            s.hsd = in_rng(a, `PRD_HSD_LO, `PRD_HSD_HI);
            s.lsd = in_rng(a, `PRD_LSD_LO, `PRD_LSD_HI);
            s.lin = in_rng(a, `PRD_LIN_LO, `PRD_LIN_HI);
            s.supply_sense_block = in_rng(a, `PRD_SUPPLY_SENSE_BLOCK_LO, `PRD_SUPPLY_SENSE_BLOCK_HI);
            s.pflash = in_rng(a, `PRD_PFL_LO, `PRD_PFL_HI);
        end
        // anything not matched above stays all-zero and is handled as reserved
        decode = s;
    endfunction

    // next-state logic for the whole block
    always_comb
    begin
        d = q;

        // three-stage synchronisers; a level counts once stages two and three agree
        d.rst_sync = {q.rst_sync[1:0], RESET_PIN_I};
        d.dbg_sync = {q.dbg_sync[1:0], DEBUG_MODE_PIN_I};
        if (q.dbg_sync[1] == q.dbg_sync[2])
        begin
            d.dbg_filt = q.dbg_sync[2];
        end
        if (q.rst_sync[1] == q.rst_sync[2])
        begin
            d.rst_filt = q.rst_sync[2];
            // release edge of the pin: the mode pin is still held by the outside party
            if (q.rst_sync[2] && !q.rst_filt)
            begin
                d.mode = q.dbg_filt;
            end
        end

        // pin driven low while an internal source asks for reset; outside low resets the chip
        d.drv_rst    = INT_RESET_REQ;
        d.chip_rst_n = q.rst_filt && !INT_RESET_REQ;

        // peripheral strobes last exactly one cycle
        d.sel    = '0;
        d.per_we = 1'b0;
        d.per_re = 1'b0;

        // write address and data are taken independently, in either order
        if (S_AXI_AWVALID && q.awready)
        begin
            d.aw_have = 1'b1;
            d.addr    = S_AXI_AWADDR[17:2];
            d.addr_ok = (S_AXI_AWADDR[31:18] == 14'h0000);
        end
        if (S_AXI_WVALID && q.wready)
        begin
            d.w_have = 1'b1;
            d.wbyte  = S_AXI_WDATA[7:0];
            d.wen    = S_AXI_WSTRB[0];
        end

        unique case (q.state)
            prd_pkg::PRD_ST_IDLE:
            begin
                // a read already accepted by arready wins; otherwise a complete write starts
                if (S_AXI_ARVALID && q.arready)
                begin
                    d.addr    = S_AXI_ARADDR[17:2];
                    d.addr_ok = (S_AXI_ARADDR[31:18] == 14'h0000);
                    d.state   = prd_pkg::PRD_ST_RACC;
                end
                else if (q.aw_have && q.w_have)
                begin
                    d.state = prd_pkg::PRD_ST_WACC;
                end
            end
            prd_pkg::PRD_ST_WACC:
            begin
                // a lane-0 strobe of zero writes nothing anywhere
                if (q.wen)
                begin
                    d.sel       = decode(q.addr, q.addr_ok);
                    d.per_we    = |decode(q.addr, q.addr_ok);
                    d.per_addr  = q.addr;
                    d.per_wdata = q.wbyte;
                    d.flash_addr = {q.program_page_register, q.addr[13:0]};
                    if (q.addr_ok && (q.addr == `PRD_PROGRAM_PAGE_REGISTER_IDX))
                    begin
                        d.program_page_register = q.wbyte[3:0];
                    end
                    if (q.addr_ok)
                    begin
                        unique case (q.addr)
                            `PRD_PULL_IDX + 16'h0000: d.pull.ad_en = q.wbyte[5:0];
                            `PRD_PULL_IDX + 16'h0001: d.pull.ad_up = q.wbyte[5:0];
                            `PRD_PULL_IDX + 16'h0002: d.pull.p_en  = q.wbyte[5:0];
                            `PRD_PULL_IDX + 16'h0003: d.pull.p_up  = q.wbyte[5:0];
                            `PRD_PULL_IDX + 16'h0004: d.pull.s_en  = q.wbyte[5:0];
                            `PRD_PULL_IDX + 16'h0005: d.pull.s_up  = q.wbyte[5:0];
                            `PRD_PULL_IDX + 16'h0006: d.pull.t_en  = q.wbyte[3:0];
                            `PRD_PULL_IDX + 16'h0007: d.pull.t_up  = q.wbyte[3:0];
                            `PRD_PULL_LAST:           d.pull.e_dn  = q.wbyte[0];
                            default:                  d.pull = q.pull; // id bytes land here
                        endcase
                    end
                end
                d.bvalid = 1'b1;
                d.state  = prd_pkg::PRD_ST_BRESP;
            end
            prd_pkg::PRD_ST_BRESP:
            begin
                if (S_AXI_BREADY)
                begin
                    d.bvalid  = 1'b0;
                    d.aw_have = 1'b0;
                    d.w_have  = 1'b0;
                    d.state   = prd_pkg::PRD_ST_IDLE;
                end
            end
            prd_pkg::PRD_ST_RACC:
            begin
                d.sel       = decode(q.addr, q.addr_ok);
                d.per_re    = |decode(q.addr, q.addr_ok);
                d.per_addr  = q.addr;
                d.flash_addr = {q.program_page_register, q.addr[13:0]};
                d.state     = prd_pkg::PRD_ST_RWAIT;
            end
            prd_pkg::PRD_ST_RWAIT:
            begin
                // select is up this cycle; internal registers override the peripheral data
                d.rdata = (|q.sel) ? PERIPH_RDATA : 8'h00;
                if (q.addr_ok)
                begin
                    unique case (q.addr)
                        `PRD_IDH_IDX:             d.rdata = PART_ID[15:8];
                        `PRD_IDL_IDX:             d.rdata = PART_ID[7:0];
                        `PRD_MODE_IDX:            d.rdata = {7'h00, q.mode};
                        `PRD_PROGRAM_PAGE_REGISTER_IDX:           d.rdata = {4'h0, q.program_page_register};
                        `PRD_PULL_IDX + 16'h0000: d.rdata = {2'h0, q.pull.ad_en};
                        `PRD_PULL_IDX + 16'h0001: d.rdata = {2'h0, q.pull.ad_up};
                        `PRD_PULL_IDX + 16'h0002: d.rdata = {2'h0, q.pull.p_en};
                        `PRD_PULL_IDX + 16'h0003: d.rdata = {2'h0, q.pull.p_up};
                        `PRD_PULL_IDX + 16'h0004: d.rdata = {2'h0, q.pull.s_en};
                        `PRD_PULL_IDX + 16'h0005: d.rdata = {2'h0, q.pull.s_up};
                        `PRD_PULL_IDX + 16'h0006: d.rdata = {4'h0, q.pull.t_en};
                        `PRD_PULL_IDX + 16'h0007: d.rdata = {4'h0, q.pull.t_up};
                        `PRD_PULL_LAST:           d.rdata = {7'h00, q.pull.e_dn};
                        default:                  d.rdata = d.rdata;
                    endcase
                end
                d.rvalid = 1'b1;
                d.state  = prd_pkg::PRD_ST_RRESP;
            end
            prd_pkg::PRD_ST_RRESP:
            begin
                if (S_AXI_RREADY)
                begin
                    d.rvalid = 1'b0;
                    d.state  = prd_pkg::PRD_ST_IDLE;
                end
            end
        endcase

        // an outside reset pulse puts the program page register and the pull controls back to their defaults
        if (!q.rst_filt)
        begin
            d.program_page_register = `PRD_PROGRAM_PAGE_REGISTER_RST;
            d.pull  = `PRD_PULL_RST;
        end

        // readies are registered, so derive them from the next state
        d.awready = !d.aw_have;
        d.wready  = !d.w_have;
        d.arready = (d.state == prd_pkg::PRD_ST_IDLE) && !(d.aw_have && d.w_have);
    end

    // single state register; reset values are constants only
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            q          <= '0;
            q.state    <= prd_pkg::PRD_ST_IDLE;
            q.awready  <= 1'b1;
            q.wready   <= 1'b1;
            q.arready  <= 1'b1;
            q.program_page_register    <= `PRD_PROGRAM_PAGE_REGISTER_RST;
            q.pull     <= `PRD_PULL_RST;
            q.rst_sync <= 3'h7;
            q.dbg_sync <= 3'h7;
            q.rst_filt <= 1'b1;
            q.dbg_filt <= 1'b1;
            q.mode     <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state record; responses are always okay
    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY  = q.wready;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_BRESP   = 2'h0;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RVALID  = q.rvalid;
    assign S_AXI_RRESP   = 2'h0;
    assign S_AXI_RDATA   = {24'h00_0000, q.rdata};
    assign PERIPH_SEL    = q.sel;
    assign PERIPH_ADDR   = q.per_addr;
    assign PERIPH_WDATA  = q.per_wdata;
    assign PERIPH_WE     = q.per_we;
    assign PERIPH_RE     = q.per_re;
    assign FLASH_ADDR    = q.flash_addr;
    assign RESET_PIN_O   = 1'b0;          // only ever pulls low
    assign RESET_PIN_OE  = q.drv_rst;
    assign MODE_SELECT   = q.mode;
    assign CHIP_RESET_N  = q.chip_rst_n;
    assign PULL          = q.pull;

endmodule // prd_decode

// >>> sim/prd_decode_assertions.sv
// checker for the register decoder: bus timing, select pulses, reset pin, mode latch, pull defaults
// assumes it is bound onto prd_decode and watches only ports of that module
`timescale 1ns/1ps
module prd_decode_assertions (
    input wire logic                  CLK_SYS,
    input wire logic                  RSTN,
    input wire logic                  S_AXI_ARVALID,
    input wire logic                  S_AXI_ARREADY,
    input wire logic                  S_AXI_RVALID,
    input wire logic                  S_AXI_RREADY,
    input wire logic [31:0]           S_AXI_RDATA,
    input wire logic                  S_AXI_BVALID,
    input wire logic                  S_AXI_BREADY,
    input wire prd_pkg::prd_sel_type  PERIPH_SEL,
    input wire logic                  PERIPH_WE,
    input wire logic                  PERIPH_RE,
    input wire logic                  INT_RESET_REQ,
    input wire logic                  RESET_PIN_O,
    input wire logic                  RESET_PIN_OE,
    input wire logic                  MODE_SELECT,
    input wire logic                  CHIP_RESET_N,
    input wire prd_pkg::prd_pull_type PULL
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    property p_one_sel; $onehot0(PERIPH_SEL); endproperty
    a_one_sel: assert property (p_one_sel) else $error("two module selects at once");
    property p_we_sel; PERIPH_WE |-> PERIPH_SEL != '0; endproperty
    a_we_sel: assert property (p_we_sel) else $error("write strobe with no select");
    property p_strobe_once; PERIPH_WE || PERIPH_RE |=> !PERIPH_WE && !PERIPH_RE; endproperty
    a_strobe_once: assert property (p_strobe_once) else $error("strobe longer than one cycle");
    property p_rd_time; S_AXI_ARVALID && S_AXI_ARREADY |-> ##[3:4] S_AXI_RVALID; endproperty
    a_rd_time: assert property (p_rd_time) else $error("read answer late");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_r_byte; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000; endproperty
    a_r_byte: assert property (p_r_byte) else $error("upper read bits not zero");
    property p_pin_drv; INT_RESET_REQ |=> RESET_PIN_OE && !RESET_PIN_O && !CHIP_RESET_N; endproperty
    a_pin_drv: assert property (p_pin_drv) else $error("internal reset not on pin");
    // the mode bit may only move on the pin's rising edge, while the chip is still held
    property p_mode_edge; !$stable(MODE_SELECT) |-> !$past(CHIP_RESET_N); endproperty
    a_mode_edge: assert property (p_mode_edge) else $error("mode bit moved outside reset");
    property p_pull_rst; !CHIP_RESET_N [*8] |-> PULL.ad_en == 6'h00 && PULL.p_en == 6'h00 && PULL.t_en == 4'h0
        && PULL.s_en == 6'h3F && PULL.s_up == 6'h3F && PULL.e_dn; endproperty
    a_pull_rst: assert property (p_pull_rst) else $error("pull defaults lost in reset");

    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_mode: cover property (!$stable(MODE_SELECT));
endmodule // prd_decode_assertions

bind prd_decode prd_decode_assertions u_chk (.*);

// >>> sim/prd_periph_model.sv
// far-side peripheral stand-in: answers reads combinationally while any select is high
// assumes one shared read bus; unselected it shows a pattern that flips every clock
`timescale 1ns/1ps
module prd_periph_model (
    input  wire logic                 clk,
    input  wire prd_pkg::prd_sel_type sel,
    input  wire logic [15:0]          addr,
    output logic [7:0]                rdata
);
    logic flip_q = 1'b0;

    // an idle bus must never look like a stale answer
    always_ff @(posedge clk) flip_q <= !flip_q;
    assign rdata = (sel != '0) ? ~addr[7:0] : {8{flip_q}};
endmodule // prd_periph_model

// >>> sim/prd_decode_tb_top.sv
// self-checking bench for the register decoder: axi4-lite master, pin stimulus, scenario tasks
// assumes prd_decode with its bound checker and the peripheral stand-in
`timescale 1ns/1ps
module prd_decode_tb_top;
    localparam logic [15:0] PART_ID = 16'h1E5D; // arbitrary value
    // reserved entries carry 8'hFF in place of the select bit number
    localparam logic [23:0] MAP [36] = '{24'h10_0000, 24'h10_0009, 24'h0F_000A, 24'h10_000C, 24'hFF_000E,
        24'h0F_0017, 24'hFF_0018, 24'h10_001F, 24'h0E_002F, 24'hFF_0030, 24'h0D_0034, 24'h0C_006F,
        24'h0B_0070, 24'h0A_00C7, 24'h09_00C8, 24'h08_00D7, 24'h07_00DF, 24'hFF_00E0, 24'h06_0113,
        24'hFF_0114, 24'h05_0120, 24'hFF_0121, 24'h04_0147, 24'hFF_0148, 24'h03_0150, 24'h02_0167,
        24'h01_0170, 24'hFF_0178, 24'h10_0240, 24'h10_027F, 24'hFF_0280, 24'h0D_02F0, 24'h0D_02FF,
        24'hFF_0300, 24'hFF_7FFF, 24'h00_8000};
    logic        CLK_SYS = 1'b0, RSTN = 1'b0, INT_RESET_REQ = 1'b0, DEBUG_MODE_PIN_I = 1'b0, ext_low = 1'b1;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
    logic        S_AXI_RREADY = 1'b0, we_seen = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic        S_AXI_ARREADY, S_AXI_RVALID, PERIPH_WE, PERIPH_RE, RESET_PIN_I, RESET_PIN_O, RESET_PIN_OE;
    logic        MODE_SELECT, CHIP_RESET_N;
    logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB = 4'h1;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [15:0] PERIPH_ADDR;
    logic [7:0]  PERIPH_WDATA, PERIPH_RDATA;
    logic [17:0] FLASH_ADDR, fl = '0;
    logic [16:0] seen = '0;
    prd_pkg::prd_sel_type  PERIPH_SEL;
    prd_pkg::prd_pull_type PULL;
    int          miscompares = 0, tests_run = 0;

    prd_decode #(.PART_ID(PART_ID)) DUT (.*);
    prd_periph_model u_periph (.clk(CLK_SYS), .sel(PERIPH_SEL), .addr(PERIPH_ADDR), .rdata(PERIPH_RDATA));

    // pin has a pull-up; low when either side pulls it down
    assign RESET_PIN_I = !(RESET_PIN_OE || ext_low);

    initial
    begin
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    // sampled mid-cycle so a task returning on the pulse edge already sees it
    always @(negedge CLK_SYS)
    begin
        if (PERIPH_SEL != '0) seen <= PERIPH_SEL;
        if (PERIPH_WE) we_seen <= (PERIPH_WDATA === 8'h3C); // write data must ride with the strobe
        if (PERIPH_RE) we_seen <= 1'b1;
        if (PERIPH_SEL.pflash) fl <= FLASH_ADDR;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bit ap = 1'b1;
        bit wp = 1'b1;
        @(posedge CLK_SYS);
        S_AXI_AWADDR <= {14'h0, a, 2'b00};
        S_AXI_WDATA <= {24'h0, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (ap || wp)
        begin
            @(posedge CLK_SYS);
            if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
            ap = ap && S_AXI_AWREADY !== 1'b1;
            wp = wp && S_AXI_WREADY !== 1'b1;
        end
        while (S_AXI_BVALID !== 1'b1) @(posedge CLK_SYS);
        chk({30'h0, S_AXI_BRESP}, 32'h0000_0000);
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        S_AXI_ARADDR <= {14'h0, a, 2'b00};
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
        d = S_AXI_RDATA;
        chk({30'h0, S_AXI_RRESP}, 32'h0000_0000);
        S_AXI_RREADY <= 1'b0;
    endtask

    task automatic chk_pull;
        chk({3'h0, PULL.ad_en, PULL.p_en, PULL.t_en, PULL.s_en, PULL.s_up, PULL.e_dn}, 32'h0000_1FFF);
    endtask

    // the module range edges and gaps listed in MAP: write then read, select and data judged
    task automatic t_map;
        logic [31:0] d;
        logic [15:0] a;
        logic [16:0] e;
        foreach (MAP[i])
        begin
            a = MAP[i][15:0];
            e = (MAP[i][23:16] == 8'hFF) ? 17'h0 : 17'h1 << MAP[i][23:16];
            seen = '0;
            we_seen = 1'b0;
            wr(a, 8'h3C);
            chk({14'h0, we_seen, seen}, {14'h0, e != 17'h0, e});
            seen = '0;
            we_seen = 1'b0;
            rd(a, d);
            chk({14'h0, we_seen, seen}, {14'h0, e != 17'h0, e});
            chk(d, {24'h0, (e != 17'h0) ? ~a[7:0] : 8'h00});
        end
    endtask

    task automatic t_id;
        logic [31:0] d;
        wr(16'h001A, 8'hFF);
        seen = '0;
        rd(16'h001A, d);
        chk(d, {24'h0, PART_ID[15:8]});
        rd(16'h001B, d);
        chk(d, {24'h0, PART_ID[7:0]});
        chk({15'h0, seen}, 32'h0000_0000);
    endtask

    // paging into the flash window inside it and at its top end, then per-pin pull control
    task automatic t_regs;
        logic [31:0] d;
        wr(16'h0015, 8'h0B);
        wr(16'h9234, 8'h11);
        chk({14'h0, fl}, {14'h0, 4'hB, 14'h1234});
        wr(16'h0015, 8'h0F);
        rd(16'hBFFF, d);
        chk({14'h0, fl}, 32'h0003_FFFF);
        rd(16'h0015, d);
        chk(d, 32'h0000_000F);
        wr(16'h0250, 8'h2A);
        wr(16'h0254, 8'h05);
        wr(16'h0258, 8'h00);
        @(posedge CLK_SYS);
        chk({19'h0, PULL.ad_en, PULL.s_en, PULL.e_dn}, 32'h0000_150A);
    endtask

    task automatic t_intrst;
        logic [31:0] d;
        @(posedge CLK_SYS);
        INT_RESET_REQ <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        chk({30'h0, RESET_PIN_OE, CHIP_RESET_N}, 32'h0000_0002);
        repeat (8) @(posedge CLK_SYS);
        INT_RESET_REQ <= 1'b0;
        repeat (12) @(posedge CLK_SYS);
        chk_pull();
        chk({31'h0, MODE_SELECT}, 32'h0000_0001);
        rd(16'h0011, d);
        chk(d, 32'h0000_0001);
        rd(16'h0015, d);
        chk(d, 32'h0000_0000);
    endtask

    task automatic results;
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        results();
    end

    // mode level is held low through the pin's rising edge, raised only afterwards
    initial
    begin
        repeat (5) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        chk_pull();
        repeat (3) @(posedge CLK_SYS);
        ext_low <= 1'b0;
        repeat (10) @(posedge CLK_SYS);
        DEBUG_MODE_PIN_I <= 1'b1;
        chk({31'h0, MODE_SELECT}, 32'h0000_0000);
        chk({31'h0, CHIP_RESET_N}, 32'h0000_0001);
        t_map();
        t_id();
        t_regs();
        t_intrst();
        results();
    end
endmodule // prd_decode_tb_top
